// file: rtl/ebr_bridge.sv
/*
 external processor bus to memory-mapped fabric master bridge.
 assumes all processor pins are synchronous to clk, the bus reference clock,
 and that the processor holds its request until it samples cpu_wait low.
*/
`timescale 1ns/10ps
`include "ebr_regs.svh"
module ebr_bridge (
   input  wire logic                     clk,
   input  wire logic                     rstn,
   input  wire ebr_pkg::ebr_wmode_t      wmode,
   input  wire logic                     split_bus,
   input  wire logic [`EBR_WADDR_W-1:0]  cpu_addr,
   input  wire logic [`EBR_BE_W-1:0]     cpu_be,
   input  wire logic                     cpu_rd,
   input  wire logic                     cpu_wr,
   input  wire logic [`EBR_DATA_W-1:0]   cpu_wdata,
   output logic [`EBR_DATA_W-1:0]        cpu_rdata,
   input  wire logic [`EBR_DATA_W-1:0]   cpu_dq_in,
   output logic [`EBR_DATA_W-1:0]        cpu_dq_out,
   output logic                          cpu_dq_oe,
   input  wire logic                     cpu_oe,
   output logic                          cpu_wait,
   output logic [`EBR_BADDR_W-1:0]       address,
   output logic [`EBR_BE_W-1:0]          byteenable,
   output logic                          read,
   output logic                          write,
   output logic [`EBR_DATA_W-1:0]        writedata,
   input  wire logic [`EBR_DATA_W-1:0]   readdata,
   input  wire logic                     readdatavalid,
   input  wire logic                     waitrequest
);
   import ebr_pkg::*;

   logic [`EBR_BADDR_W-1:0] baddr;
   ebr_state_t              state_r;
   logic                    cpu_req;
   logic                    done_now;

   // fabric takes the open transfer on this edge
   function automatic logic fab_taken(input logic rd, input logic wr, input logic stall);
      return (rd | wr) & ~stall;
   endfunction : fab_taken

   // a processor cycle is open while either strobe is up
   assign cpu_req  = cpu_rd | cpu_wr;
   // completion: a write taken, or the read data back from the slave
   assign done_now = fab_taken(1'b0, write, waitrequest) | ((state_r == EBR_RDATA) & readdatavalid);

   // all pins share the bus reference clock, so no synchronisers
   ebr_addr_map u_map (
      .word_addr (cpu_addr),
      .wmode     (wmode),
      .byte_addr (baddr)
   );

   // transfer sequencer: exactly one fabric transfer per processor cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_r <= EBR_IDLE;
      end else begin
         case (state_r)
            EBR_IDLE: begin
               if (cpu_req) begin
                  state_r <= EBR_WAIT;
               end
            end
            // no time-out: a stalled transfer waits as long as the slave does
            EBR_WAIT: begin
               if (fab_taken(read, write, waitrequest)) begin
                  state_r <= read ? EBR_RDATA : EBR_DONE;
               end
            end
            // pipelined read: the processor is held until the data is back
            EBR_RDATA: begin
               if (readdatavalid) begin
                  state_r <= EBR_DONE;
               end
            end
            // the processor ends its cycle on this edge, so its strobe here is stale
            EBR_DONE: begin
               state_r <= EBR_IDLE;
            end
            default: begin
               state_r <= EBR_IDLE;
            end
         endcase
      end
   end

   // launch from idle, then hold the request unchanged while stalled; read wins if both strobes rise
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         address    <= '0;
         byteenable <= '0;
         read       <= 1'b0;
         write      <= 1'b0;
         writedata  <= '0;
      end else if (state_r == EBR_IDLE) begin
         address    <= baddr;
         byteenable <= cpu_be;
         read       <= cpu_rd;
         write      <= cpu_wr & ~cpu_rd;
         writedata  <= split_bus ? cpu_wdata : cpu_dq_in;
      end else if (fab_taken(read, write, waitrequest)) begin
         read       <= 1'b0;
         write      <= 1'b0;
      end
   end

   // wait drops for one cycle only, so a held strobe is never taken twice
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cpu_wait <= 1'b1;
      end else begin
         cpu_wait <= ~done_now;
      end
   end

   // read data path, lanes kept in fabric order
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cpu_rdata  <= '0;
         cpu_dq_out <= '0;
      end else if (readdatavalid) begin
         cpu_rdata  <= readdata;
         cpu_dq_out <= readdata;
      end
   end

   // shared pins driven only while the processor asks for data
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cpu_dq_oe <= 1'b0;
      end else begin
         cpu_dq_oe <= cpu_oe & ~split_bus;
      end
   end

   // checks
   property p_pad_zero;
      @(posedge clk) disable iff (!rstn)
      (wmode == EBR_WORD32) |-> (baddr[1:0] == 2'b00);
   endproperty
   a_pad_zero: assert property (p_pad_zero) else $error("pad bits not zero");

   property p_pad16;
      @(posedge clk) disable iff (!rstn)
      (wmode == EBR_WORD16) |-> (baddr[0] == 1'b0 && baddr[1] == cpu_addr[0]);
   endproperty
   a_pad16: assert property (p_pad16) else $error("16-bit widen wrong");

   property p_pad32;
      @(posedge clk) disable iff (!rstn)
      (wmode == EBR_WORD32) |-> (baddr[2] == cpu_addr[0]);
   endproperty
   a_pad32: assert property (p_pad32) else $error("32-bit widen wrong");

   property p_hold;
      @(posedge clk) disable iff (!rstn)
      (read | write) && waitrequest |=> $stable(address) && $stable(byteenable) && $stable(writedata);
   endproperty
   a_hold: assert property (p_hold) else $error("request changed while stalled");

   property p_be;
      @(posedge clk) disable iff (!rstn)
      (state_r == EBR_IDLE) |=> (byteenable == $past(cpu_be));
   endproperty
   a_be: assert property (p_be) else $error("byte enables altered");

   property p_oe;
      @(posedge clk) disable iff (!rstn)
      cpu_dq_oe |-> $past(cpu_oe) && !$past(split_bus);
   endproperty
   a_oe: assert property (p_oe) else $error("pins driven without enable");

   property p_rdata;
      @(posedge clk) disable iff (!rstn)
      readdatavalid |=> (cpu_rdata == $past(readdata));
   endproperty
   a_rdata: assert property (p_rdata) else $error("read data not forwarded");

   property p_wait;
      @(posedge clk) disable iff (!rstn)
      (read | write) && waitrequest |=> cpu_wait;
   endproperty
   a_wait: assert property (p_wait) else $error("stall not forwarded");

   property p_wack;
      @(posedge clk) disable iff (!rstn)
      write && !waitrequest |=> !cpu_wait && !write;
   endproperty
   a_wack: assert property (p_wack) else $error("taken write not acknowledged");

   property p_rack;
      @(posedge clk) disable iff (!rstn)
      (state_r == EBR_RDATA) && readdatavalid |=> !cpu_wait && (cpu_rdata == $past(readdata));
   endproperty
   a_rack: assert property (p_rack) else $error("read data not handed back with the strobe");

   property p_strobe;
      @(posedge clk) disable iff (!rstn)
      !cpu_wait |=> cpu_wait && !read && !write;
   endproperty
   a_strobe: assert property (p_strobe) else $error("completion strobe longer than one cycle");

   property p_excl;
      @(posedge clk) disable iff (!rstn)
      !(read && write);
   endproperty
   a_excl: assert property (p_excl) else $error("read and write issued together");

   property p_launch;
      @(posedge clk) disable iff (!rstn)
      (state_r == EBR_IDLE) && cpu_req |=>
         (read == $past(cpu_rd)) && (address == $past(baddr)) && (state_r == EBR_WAIT);
   endproperty
   a_launch: assert property (p_launch) else $error("request not launched as given");

   property p_wdata;
      @(posedge clk) disable iff (!rstn)
      (state_r == EBR_IDLE) |=> (writedata == ($past(split_bus) ? $past(cpu_wdata) : $past(cpu_dq_in)));
   endproperty
   a_wdata: assert property (p_wdata) else $error("write data taken from the wrong bus");

   property p_stall;
      @(posedge clk) disable iff (!rstn)
      (state_r == EBR_WAIT) && waitrequest |=> (state_r == EBR_WAIT);
   endproperty
   a_stall: assert property (p_stall) else $error("stalled transfer abandoned");
endmodule : ebr_bridge

// file: rtl/ebr_regs.svh
/*
 bridge constants: address widths, data widths and fixed fill values.
 assumes inclusion by the bridge package and modules only.
*/
// Operation
// - With a 16-bit word bus the bridge appends one low address bit to make a byte address.
// - With a 32-bit word bus the bridge appends two low address bits to make a byte address.
// - Every appended low address bit is driven to zero at all times.
// - The processor picks byte lanes with byte enables and the bridge passes them on unchanged.
// - The processor bus reference clock clocks the bridge as one synchronous interface.
// - The bridge has no time-out, so a stalled transfer waits as long as the slave stalls.
// - Separate processor read and write buses map straight onto fabric read and write data.
// - On a shared data bus the bridge drives read data only while the processor output enable asks.
// - Processor controls that already follow fabric semantics pass through without conversion.
// - Byte offset zero sits on data bits seven to zero on every fabric port.
`ifndef EBR_REGS_SVH
`define EBR_REGS_SVH
`define EBR_WADDR_W   30
`define EBR_DATA_W    32
`define EBR_BE_W      4
`define EBR_BYTE_W    8
`define EBR_PAD16     1
`define EBR_PAD32     2
`define EBR_PAD_MAX   2
`define EBR_BADDR_W   32
`endif

// file: rtl/ebr_pkg.sv
/*
 bridge types: word-size mode and transfer state.
 assumes the constants header is on the include path.
*/
`include "ebr_regs.svh"
package ebr_pkg;
   typedef enum logic {EBR_WORD16, EBR_WORD32} ebr_wmode_t;
   typedef enum logic [1:0] {EBR_IDLE, EBR_WAIT, EBR_RDATA, EBR_DONE} ebr_state_t;
endpackage : ebr_pkg

// file: rtl/ebr_addr_map.sv
/*
 word to byte address widening for the bridge.
 assumes the word-size mode is static during traffic.
*/
`timescale 1ns/10ps
`include "ebr_regs.svh"
module ebr_addr_map (
   input  wire logic [`EBR_WADDR_W-1:0] word_addr,
   input  wire ebr_pkg::ebr_wmode_t     wmode,
   output logic [`EBR_BADDR_W-1:0]      byte_addr
);
   import ebr_pkg::*;
   // shift left and fill with zeros; in 16-bit mode the top byte-address bit stays zero
   always_comb begin
      if (wmode == EBR_WORD16) begin
         byte_addr = {1'b0, word_addr, {`EBR_PAD16{1'b0}}};
      end else begin
         byte_addr = {word_addr[`EBR_BADDR_W-`EBR_PAD32-1:0], 2'b00};
      end
   end
endmodule : ebr_addr_map

// file: verif/ebr_slave.sv
/*
 fabric slave model that answers the bridge with stalls and read data.
 assumes the bridge holds its request while waitrequest is high.
*/
`timescale 1ns/10ps
module ebr_slave (
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic [7:0]  stall,
   input  wire logic [31:0] address,
   input  wire logic        read,
   input  wire logic        write,
   output logic [31:0]      readdata,
   output logic             readdatavalid,
   output logic             waitrequest
);
   logic [7:0] cnt_r;
   // stall for up to 255 cycles, as set by stall; nothing gives up early
   assign waitrequest = (read | write) && cnt_r != stall;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_r <= 8'h0;
         readdatavalid <= 1'b0;
         readdata <= 32'h0;
      end else begin
         cnt_r <= waitrequest ? cnt_r + 8'h1 : 8'h0;
         readdatavalid <= read && !waitrequest;
         // invalid data toggles so stale values never match
         readdata <= (read && !waitrequest) ? address ^ 32'h5a5aa5a5 : ~readdata;
      end
   end
endmodule : ebr_slave

// file: verif/ebr_bridge_tb.sv
/*
 random and corner transfers through the bridge against a slave model.
 assumes the bridge modules and package are compiled first.
*/
`timescale 1ns/10ps
module ebr_bridge_tb;
   import ebr_pkg::*;
   logic        clk, rstn, split_bus, cpu_rd, cpu_wr, cpu_oe, cpu_wait, cpu_dq_oe;
   logic        read, write, rdv, wreq, ew;
   ebr_wmode_t  wmode;
   logic [29:0] cpu_addr;
   logic [3:0]  cpu_be, byteenable, eb;
   logic [31:0] cpu_wdata, cpu_rdata, cpu_dq_in, cpu_dq_out, address, writedata, readdata, rnd, ea, ed;
   logic [7:0]  stall;
   int          n_fail, n_compared;
   ebr_bridge dut (.clk(clk), .rstn(rstn), .wmode(wmode), .split_bus(split_bus), .cpu_addr(cpu_addr),
      .cpu_be(cpu_be), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
      .cpu_dq_in(cpu_dq_in), .cpu_dq_out(cpu_dq_out), .cpu_dq_oe(cpu_dq_oe), .cpu_oe(cpu_oe),
      .cpu_wait(cpu_wait), .address(address), .byteenable(byteenable), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata), .readdatavalid(rdv), .waitrequest(wreq));
   ebr_slave slv (.clk(clk), .rstn(rstn), .stall(stall), .address(address), .read(read),
      .write(write), .readdata(readdata), .readdatavalid(rdv), .waitrequest(wreq));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction : lfsr
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %0t saw %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic finish_test;
      $display("mismatches %0d of %0d", n_fail, n_compared);
      if (n_fail == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : finish_test
   // one transfer, held until the stall drops
   task automatic xfer(input logic w, input logic [7:0] st);
      int k;
      rnd = lfsr(rnd);
      ed = lfsr(rnd);
      eb = rnd[3:0];
      ew = w;
      ea = (wmode == EBR_WORD16) ? {1'b0, rnd[29:0], 1'b0} : {rnd[29:0], 2'b00};
      cpu_addr <= rnd[29:0];
      cpu_be <= eb;
      cpu_wdata <= ed;
      cpu_dq_in <= split_bus ? ~ed : ed; // wrong bus choice shows in split mode only
      cpu_oe <= !w;
      stall <= st;
      cpu_rd <= !w;
      cpu_wr <= w;
      @(posedge clk);
      k = 0;
      // request held until the wait line is seen low; read data taken at that edge
      do begin
         @(posedge clk);
         k++;
      end while (cpu_wait !== 1'b0 && k < 300);
      if (k >= 300) n_fail++;
      check(32'(k), 32'(st) + (w ? 32'h2 : 32'h3));
      check({31'h0, cpu_dq_oe}, {31'h0, !w && !split_bus});
      if (!w) check(split_bus ? cpu_rdata : cpu_dq_out, ea ^ 32'h5a5aa5a5);
      cpu_rd <= 1'b0;
      cpu_wr <= 1'b0;
      cpu_oe <= 1'b0;
      @(posedge clk);
   endtask : xfer
   // fabric side seen at the accepting edge
   always @(posedge clk) begin
      if ((read | write) && wreq === 1'b0) begin
         check(address, ea);
         check({28'h0, byteenable}, {28'h0, eb});
         check({30'h0, read, write}, {30'h0, !ew, ew});
         if (write) check(writedata, ed);
      end
   end
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial begin
      #100000;
      n_fail++;
      finish_test;
   end
   initial begin
      {rstn, split_bus, cpu_rd, cpu_wr, cpu_oe, cpu_addr, cpu_be, cpu_wdata, cpu_dq_in, stall} = '0;
      wmode = EBR_WORD32;
      n_fail = 0;
      n_compared = 0;
      rnd = 32'h24;
      repeat (6) @(posedge clk);
      check({28'h0, cpu_wait, read, write, cpu_dq_oe}, 32'h8);
      rstn <= 1'b1;
      for (int i = 0; i < 40; i++) begin
         wmode <= ebr_wmode_t'(rnd[4]);
         split_bus <= rnd[5];
         @(posedge clk);
         xfer(rnd[6], {6'h0, rnd[8:7]});
      end
      // reset again in mid-run, then the first request on the first edge after release
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      check({28'h0, cpu_wait, read, write, cpu_dq_oe}, 32'h8);
      rstn <= 1'b1;
      xfer(1'b0, 8'h3c);
      xfer(1'b1, 8'h3c);
      finish_test;
   end
endmodule : ebr_bridge_tb
